// ==== logic/vtr_pkg.sv ====
// Package: register map, reset values and threshold scaling for channel two limits
package vtr_pkg;

  localparam logic [7:0] OFS_FAST_LOW   = 8'h30;
  localparam logic [7:0] OFS_FAST_HIGH  = 8'h31;
  localparam logic [7:0] OFS_SLOW_LOW   = 8'h32;
  localparam logic [7:0] RST_FAST_LOW   = 8'h00;
  localparam logic [7:0] RST_FAST_HIGH  = 8'hff;
  localparam logic [7:0] RST_SLOW_LOW   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Millivolt mapping: base plus code times step
  localparam logic [12:0] BASE_1X_MV    = 13'h0c8;
  localparam logic [12:0] STEP_1X_MV    = 13'h005;
  localparam logic [12:0] BASE_4X_MV    = 13'h320;
  localparam logic [12:0] STEP_4X_MV    = 13'h014;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vtr_req_s;

endpackage : vtr_pkg

// ==== logic/vtr_code_to_mv.sv ====
// Limit code to millivolt conversion under range scaling
`timescale 1ns/1ps
module vtr_code_to_mv (
  // Code and scale
  input  wire logic [7:0]  code_i,
  input  wire logic        scale_4x_i,
  // Result
  output logic      [12:0] mv_o
);

  wire [12:0] base_w = scale_4x_i ? vtr_pkg::BASE_4X_MV : vtr_pkg::BASE_1X_MV;
  wire [12:0] step_w = scale_4x_i ? vtr_pkg::STEP_4X_MV : vtr_pkg::STEP_1X_MV;
  wire [25:0] prod_w = {5'h00, code_i} * step_w;

  assign mv_o = base_w + prod_w[12:0];

endmodule : vtr_code_to_mv

// ==== logic/vtr_ch2_thresholds.sv ====
// Channel two threshold registers with window comparison
`timescale 1ns/1ps
module vtr_ch2_thresholds (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_b_i,
  // Register access
  input  wire vtr_pkg::vtr_req_s   req_i,
  output logic [7:0]               rdata_o,
  // Scaling and measured levels in millivolts
  input  wire logic                range_scaling_select_i,
  input  wire logic [12:0]         fast_level_mv_i,
  input  wire logic [12:0]         slow_level_mv_i,
  // Flags
  output logic                     fast_under_o,
  output logic                     fast_over_o,
  output logic                     slow_under_o,
  // Limit values for the comparators
  output logic [12:0]              fast_low_mv_o,
  output logic [12:0]              fast_high_mv_o,
  output logic [12:0]              slow_low_mv_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  ch2_fast_path_low_limit_r;
  logic [7:0]  ch2_fast_path_high_limit_r;
  logic [7:0]  ch2_slow_path_low_limit_r;
  logic [7:0]  rdata_nxt;

  wire sel_fl_w = req_i.addr == vtr_pkg::OFS_FAST_LOW;
  wire sel_fh_w = req_i.addr == vtr_pkg::OFS_FAST_HIGH;
  wire sel_sl_w = req_i.addr == vtr_pkg::OFS_SLOW_LOW;
  wire any_sel_w = sel_fl_w | sel_fh_w | sel_sl_w;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch2_fast_path_low_limit_r  <= vtr_pkg::RST_FAST_LOW;
      ch2_fast_path_high_limit_r <= vtr_pkg::RST_FAST_HIGH;
      ch2_slow_path_low_limit_r  <= vtr_pkg::RST_SLOW_LOW;
    end else if (req_i.wr) begin
      if (sel_fl_w) ch2_fast_path_low_limit_r  <= req_i.wdata;
      if (sel_fh_w) ch2_fast_path_high_limit_r <= req_i.wdata;
      if (sel_sl_w) ch2_slow_path_low_limit_r  <= req_i.wdata;
    end
  end

  assign rdata_nxt = sel_fl_w ? ch2_fast_path_low_limit_r :
                     sel_fh_w ? ch2_fast_path_high_limit_r :
                     sel_sl_w ? ch2_slow_path_low_limit_r : vtr_pkg::UNMAPPED_READ;

  // Read data registered, valid the cycle after rd
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) rdata_o <= 8'h00;
    else if (req_i.rd) rdata_o <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  vtr_code_to_mv u_fl (
    .code_i     (ch2_fast_path_low_limit_r),
    .scale_4x_i (range_scaling_select_i),
    .mv_o       (fast_low_mv_o)
  );
  vtr_code_to_mv u_fh (
    .code_i     (ch2_fast_path_high_limit_r),
    .scale_4x_i (range_scaling_select_i),
    .mv_o       (fast_high_mv_o)
  );
  vtr_code_to_mv u_sl (
    .code_i     (ch2_slow_path_low_limit_r),
    .scale_4x_i (range_scaling_select_i),
    .mv_o       (slow_low_mv_o)
  );

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast_under_o <= 1'b0;
      fast_over_o  <= 1'b0;
      slow_under_o <= 1'b0;
    end else begin
      fast_under_o <= fast_level_mv_i < fast_low_mv_o;
      fast_over_o  <= fast_level_mv_i > fast_high_mv_o;
      slow_under_o <= slow_level_mv_i < slow_low_mv_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases for multi-step checks
  sequence seq_fh_write;
    req_i.wr && !req_i.rd && sel_fh_w;
  endsequence
  sequence seq_bus_idle;
    !req_i.wr && !req_i.rd;
  endsequence
  sequence seq_fh_read;
    req_i.rd && !req_i.wr && sel_fh_w;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writes
  chk_reset_limits: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |->
      ch2_fast_path_low_limit_r == vtr_pkg::RST_FAST_LOW &&
      ch2_fast_path_high_limit_r == vtr_pkg::RST_FAST_HIGH &&
      ch2_slow_path_low_limit_r == vtr_pkg::RST_SLOW_LOW)
    else $error("limits not at reset values");

  chk_flags_reset: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |->
      !fast_under_o && !fast_over_o && !slow_under_o && rdata_o == 8'h00)
    else $error("flags or read data not cleared by reset");

  chk_fast_low_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.wr && sel_fl_w |=> ch2_fast_path_low_limit_r == $past(req_i.wdata))
    else $error("fast low limit not written");

  chk_fast_high_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.wr && sel_fh_w |=> ch2_fast_path_high_limit_r == $past(req_i.wdata))
    else $error("fast high limit not written");

  chk_slow_low_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.wr && sel_sl_w |=> ch2_slow_path_low_limit_r == $past(req_i.wdata))
    else $error("slow low limit not written");

  chk_unmapped_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.wr && !any_sel_w |=>
      $stable(ch2_fast_path_low_limit_r) && $stable(ch2_fast_path_high_limit_r) &&
      $stable(ch2_slow_path_low_limit_r))
    else $error("unmapped write changed a limit");

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  chk_read_fast_low: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.rd && !req_i.wr && sel_fl_w |=> rdata_o == ch2_fast_path_low_limit_r)
    else $error("fast low read data mismatch");

  chk_read_back: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.rd && !req_i.wr && sel_fh_w |=> rdata_o == ch2_fast_path_high_limit_r)
    else $error("read data mismatch");

  chk_read_slow_low: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.rd && !req_i.wr && sel_sl_w |=> rdata_o == ch2_slow_path_low_limit_r)
    else $error("slow low read data mismatch");

  chk_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    req_i.rd && !any_sel_w |=> rdata_o == vtr_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  chk_read_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data changed without read");

  chk_write_then_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    seq_fh_write ##1 seq_bus_idle ##1 seq_fh_read |=>
      rdata_o == $past(req_i.wdata, 3))
    else $error("written high limit not read back");

  ////////////////////////////////////////////////////////////////////////////
  // Code to millivolt mapping
  chk_unity_scale: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !range_scaling_select_i |-> fast_low_mv_o ==
      vtr_pkg::BASE_1X_MV + 13'(ch2_fast_path_low_limit_r) * vtr_pkg::STEP_1X_MV)
    else $error("unity mapping wrong");

  chk_unity_high: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !range_scaling_select_i |-> fast_high_mv_o ==
      vtr_pkg::BASE_1X_MV + 13'(ch2_fast_path_high_limit_r) * vtr_pkg::STEP_1X_MV)
    else $error("unity high mapping wrong");

  chk_unity_slow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !range_scaling_select_i |-> slow_low_mv_o ==
      vtr_pkg::BASE_1X_MV + 13'(ch2_slow_path_low_limit_r) * vtr_pkg::STEP_1X_MV)
    else $error("unity slow mapping wrong");

  chk_four_scale: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    range_scaling_select_i |-> fast_high_mv_o ==
      vtr_pkg::BASE_4X_MV + 13'(ch2_fast_path_high_limit_r) * vtr_pkg::STEP_4X_MV)
    else $error("fourfold mapping wrong");

  chk_four_low: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    range_scaling_select_i |-> fast_low_mv_o ==
      vtr_pkg::BASE_4X_MV + 13'(ch2_fast_path_low_limit_r) * vtr_pkg::STEP_4X_MV)
    else $error("fourfold low mapping wrong");

  chk_four_slow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    range_scaling_select_i |-> slow_low_mv_o ==
      vtr_pkg::BASE_4X_MV + 13'(ch2_slow_path_low_limit_r) * vtr_pkg::STEP_4X_MV)
    else $error("fourfold slow mapping wrong");

  chk_scale_used: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $changed(range_scaling_select_i) && $stable(ch2_slow_path_low_limit_r) |->
      slow_low_mv_o != $past(slow_low_mv_o))
    else $error("scaling select ignored");

  ////////////////////////////////////////////////////////////////////////////
  // Window flags
  chk_under_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fast_level_mv_i < fast_low_mv_o |=> fast_under_o)
    else $error("under flag missing");

  chk_under_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fast_level_mv_i >= fast_low_mv_o |=> !fast_under_o)
    else $error("false under flag");

  chk_over_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fast_level_mv_i > fast_high_mv_o |=> fast_over_o)
    else $error("over flag missing");

  chk_over_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fast_level_mv_i <= fast_high_mv_o |=> !fast_over_o)
    else $error("false over flag");

  chk_slow_under_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    slow_level_mv_i < slow_low_mv_o |=> slow_under_o)
    else $error("slow under flag missing");

  chk_slow_under_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    slow_level_mv_i >= slow_low_mv_o |=> !slow_under_o)
    else $error("false slow under flag");

endmodule : vtr_ch2_thresholds

// ==== test/vtr_host_model.sv ====
// Host model: byte writes and reads on the register request port
`timescale 1ns/1ps
module vtr_host_model (
  // Bus
  input  wire logic         clock_i,
  input  wire logic [7:0]   rdata_i,
  output vtr_pkg::vtr_req_s req_o
);
  initial req_o = '0;
  // Idle address and data lines show the inverse of the last value; wr and rd go low
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clock_i);
    req_o = {w, !w, a, d};
    @(negedge clock_i);
    req_o = {2'b00, ~a, ~d};
    q = rdata_i;
  endtask : xfer
endmodule : vtr_host_model

// ==== test/tb_vtr_ch2_thresholds.sv ====
// Testbench: channel two threshold registers
`timescale 1ns/1ps
module tb_vtr_ch2_thresholds;
  logic clock_i = 0, rst_b_i = 0, scl = 0, fu, fo, su;
  logic [12:0] fl = 13'h0, sl = 13'h0, flo, fhi, slo;
  logic [7:0] rdata, q;
  vtr_pkg::vtr_req_s req;
  int failures = 0, check_count = 0, cyc = 0;
  initial forever #4 clock_i = ~clock_i;
  vtr_host_model vtr_host_model_inst (.clock_i(clock_i), .rdata_i(rdata), .req_o(req));
  vtr_ch2_thresholds vtr_ch2_thresholds_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .req_i(req), .rdata_o(rdata), .range_scaling_select_i(scl), .fast_level_mv_i(fl),
    .slow_level_mv_i(sl), .fast_under_o(fu), .fast_over_o(fo), .slow_under_o(su),
    .fast_low_mv_o(flo), .fast_high_mv_o(fhi), .slow_low_mv_o(slo));
  ////////////////////////////////////////
  task automatic chk(input logic [12:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [12:0] e);
    vtr_host_model_inst.xfer(1'b0, a, 8'h00, q);
    chk({5'h00, q}, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    vtr_host_model_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic lv(input logic [12:0] f, s, input logic [2:0] e);
    @(negedge clock_i);
    fl = f;
    sl = s;
    repeat (2) @(negedge clock_i);
    chk({10'h000, fu, fo, su}, {10'h000, e});
  endtask : lv
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  task automatic t_reset();
    rd(8'h30, 13'h000);
    rd(8'h31, 13'h0ff);
    rd(8'h32, 13'h000);
    chk(flo, 13'h0c8);
    chk(fhi, 13'h5c3);
    scl = 1'b1;
    @(negedge clock_i);
    chk(fhi, 13'h170c);
    chk(slo, 13'h320);
    scl = 1'b0;
  endtask : t_reset
  task automatic t_rw();
    wr(8'h31, 8'h5a);
    rd(8'h31, 13'h05a);
    wr(8'h30, 8'h14);
    wr(8'h31, 8'h28);
    wr(8'h32, 8'h1e);
    wr(8'h33, 8'ha5);
    rd(8'h33, 13'h000);
    rd(8'h30, 13'h014);
    rd(8'h31, 13'h028);
    rd(8'h32, 13'h01e);
  endtask : t_rw
  task automatic t_scale();
    chk(flo, 13'h12c);
    chk(fhi, 13'h190);
    chk(slo, 13'h15e);
    scl = 1'b1;
    @(negedge clock_i);
    chk(flo, 13'h4b0);
    chk(fhi, 13'h640);
    chk(slo, 13'h578);
    scl = 1'b0;
  endtask : t_scale
  task automatic t_flags();
    lv(13'h12b, 13'h15d, 3'b101);
    lv(13'h191, 13'h15e, 3'b010);
    lv(13'h12c, 13'h15e, 3'b000);
    lv(13'h190, 13'h15f, 3'b000);
    scl = 1'b1;
    lv(13'h4af, 13'h578, 3'b100);
    lv(13'h641, 13'h577, 3'b011);
    scl = 1'b0;
  endtask : t_flags
  ////////////////////////////////////////
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_reset();
    t_rw();
    t_scale();
    t_flags();
    wrap_up();
  end
endmodule : tb_vtr_ch2_thresholds
